// ### rtl/ilmc_pkg.sv
`default_nettype none
package ilmc_pkg;
   localparam logic [31:0] ADDR_IDLE_CFG   = 32'h0000_00E2;
   localparam logic [31:0] ADDR_MC_CAP     = 32'h0000_0179;
   localparam logic [31:0] ADDR_ERR_CFG    = 32'h0000_017F;
   localparam int          LIMIT_LSB       = 0;
   localparam int          LIMIT_W         = 3;
   localparam int          IO_REDIR_BIT    = 10;
   localparam int          LOCK_BIT        = 15;
   localparam int          MEMLOG_BIT      = 1;
   localparam logic [63:0] IDLE_CFG_WMASK  = 64'h0000_0000_0000_8407;
   localparam logic [63:0] ERR_CFG_WMASK   = 64'h0000_0000_0000_0002;
   localparam logic [63:0] MC_CAP_MASK     = 64'h0000_0000_05FF_0FFF;
   localparam logic [2:0]  LIM_NONE        = 3'h0;
   localparam logic [2:0]  LIM_S2          = 3'h1;
   localparam logic [2:0]  LIM_S6          = 3'h2;
   localparam logic [2:0]  LIM_S6R         = 3'h3;
   localparam logic [2:0]  LIM_S7          = 3'h4;
   localparam logic [2:0]  LIM_S7S         = 3'h5;
   localparam logic [2:0]  LIM_UNLIMITED   = 3'h7;
   // one-hot deepest allowed package idle state
   typedef enum logic [6:0] {
      ILMC_DEPTH_NONE = 7'h01,
      ILMC_DEPTH_S2   = 7'h02,
      ILMC_DEPTH_S6   = 7'h04,
      ILMC_DEPTH_S6R  = 7'h08,
      ILMC_DEPTH_S7   = 7'h10,
      ILMC_DEPTH_S7S  = 7'h20,
      ILMC_DEPTH_ANY  = 7'h40
   } ilmc_depth_t;
endpackage : ilmc_pkg
`default_nettype wire

// ### rtl/ilmc_limit_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ilmc_limit_decode (
   input  wire logic [2:0]            limit_code,
   output var  ilmc_pkg::ilmc_depth_t depth,
   output logic                       code_valid
);
   // 110b has no meaning; it maps to no-idle so nothing deeper than asked is entered
   always_comb begin
      unique case (limit_code)
         ilmc_pkg::LIM_NONE:      depth = ilmc_pkg::ILMC_DEPTH_NONE;
         ilmc_pkg::LIM_S2:        depth = ilmc_pkg::ILMC_DEPTH_S2;
         ilmc_pkg::LIM_S6:        depth = ilmc_pkg::ILMC_DEPTH_S6;
         ilmc_pkg::LIM_S6R:       depth = ilmc_pkg::ILMC_DEPTH_S6R;
         ilmc_pkg::LIM_S7:        depth = ilmc_pkg::ILMC_DEPTH_S7;
         ilmc_pkg::LIM_S7S:       depth = ilmc_pkg::ILMC_DEPTH_S7S;
         ilmc_pkg::LIM_UNLIMITED: depth = ilmc_pkg::ILMC_DEPTH_ANY;
         default:                 depth = ilmc_pkg::ILMC_DEPTH_NONE;
      endcase
   end
   assign code_valid = (limit_code != 3'h6);
endmodule : ilmc_limit_decode
`default_nettype wire

// ### rtl/ilmc_regs.sv
// Summary of operation
// - idle-state configuration register at address E2h, core scope, read/write
// - bits 2:0 set deepest package idle state; reset to factory limit
// - codes 0..5 select none, second, sixth, sixth-retained, seventh, seventh variant
// - code 111 removes any package idle depth limit
// - no code caps depth at the third idle state
// - bit 10 turns matching I/O reads into monitor-wait instructions
// - bit 15 set-once lock freezes bits 15:0 until reset
// - read-only capability register at 179h; bits 7:0 give bank count
// - error configuration register at 17Fh; bits 0 and 63:2 reserved
// - bit 1 enables extra memory controller logging in bits 36:32
`timescale 1ns/100ps
`default_nettype none
module ilmc_regs #(
   parameter logic [2:0]  FACTORY_LIMIT = 3'h7,
   parameter logic [63:0] MC_CAP_VALUE  = 64'h0000_0000_0000_0014
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        msr_wr,
   input  wire logic        msr_rd,
   input  wire logic [31:0] msr_addr,
   input  wire logic [63:0] msr_wdata,
   input  wire logic        io_rd,
   input  wire logic [15:0] io_rd_port,
   input  wire logic [15:0] io_capture_base_register,
   output logic      [63:0] msr_rdata,
   output logic             msr_fault,
   output logic      [6:0]  idle_depth_limit,
   output logic             monitor_wait_instruction,
   output logic             memory_controller_bank_log_en
);
   logic [63:0]          idle_cfg_reg;
   logic [63:0]          idle_cfg_next;
   logic [63:0]          err_cfg_reg;
   logic [63:0]          err_cfg_next;
   logic [63:0]          rdata_next;
   logic                 hit_idle;
   logic                 hit_cap;
   logic                 hit_err;
   logic                 locked;
   logic [63:0]          cap_value;
   ilmc_pkg::ilmc_depth_t depth_w;
   logic                 code_valid;
   logic [2:0]           limit_field;

   function automatic logic addr_hit(
      input logic [31:0] addr,
      input logic [31:0] match
   );
      return (addr == match);
   endfunction : addr_hit

   // reserved bits are dropped on the way in, so they can never be stored and read back
   function automatic logic [63:0] keep_writable(
      input logic [63:0] wdata,
      input logic [63:0] wmask
   );
      return wdata & wmask;
   endfunction : keep_writable

   assign hit_idle  = addr_hit(msr_addr, ilmc_pkg::ADDR_IDLE_CFG);
   assign hit_cap   = addr_hit(msr_addr, ilmc_pkg::ADDR_MC_CAP);
   assign hit_err   = addr_hit(msr_addr, ilmc_pkg::ADDR_ERR_CFG);
   assign limit_field = idle_cfg_reg[ilmc_pkg::LIMIT_LSB +: ilmc_pkg::LIMIT_W];
   assign locked    = idle_cfg_reg[ilmc_pkg::LOCK_BIT];
   assign cap_value = MC_CAP_VALUE & ilmc_pkg::MC_CAP_MASK;

   // lock only blocks writes; reset is the sole way out of it
   assign idle_cfg_next = (msr_wr && hit_idle && !locked)
                        ? keep_writable(msr_wdata, ilmc_pkg::IDLE_CFG_WMASK)
                        : idle_cfg_reg;
   assign err_cfg_next  = (msr_wr && hit_err)
                        ? keep_writable(msr_wdata, ilmc_pkg::ERR_CFG_WMASK)
                        : err_cfg_reg;
   assign rdata_next    = !msr_rd  ? msr_rdata
                        : hit_idle ? idle_cfg_reg
                        : hit_cap  ? cap_value
                        : hit_err  ? err_cfg_reg
                        : 64'h0000_0000_0000_0000;

   ilmc_limit_decode u_dec (
      .limit_code (limit_field),
      .depth      (depth_w),
      .code_valid (code_valid)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         idle_cfg_reg <= {61'h0, FACTORY_LIMIT};
         err_cfg_reg  <= 64'h0000_0000_0000_0000;
      end else begin
         idle_cfg_reg <= idle_cfg_next;
         err_cfg_reg  <= err_cfg_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         msr_rdata                     <= 64'h0000_0000_0000_0000;
         msr_fault                     <= 1'b0;
         idle_depth_limit              <= ilmc_pkg::ILMC_DEPTH_NONE;
         monitor_wait_instruction      <= 1'b0;
         memory_controller_bank_log_en <= 1'b0;
      end else begin
         msr_rdata                     <= rdata_next;
         msr_fault                     <= (msr_rd | msr_wr) & ~(hit_idle | hit_cap | hit_err);
         idle_depth_limit              <= depth_w;
         monitor_wait_instruction      <= io_rd & idle_cfg_reg[ilmc_pkg::IO_REDIR_BIT]
                                          & (io_rd_port == io_capture_base_register);
         memory_controller_bank_log_en <= err_cfg_reg[ilmc_pkg::MEMLOG_BIT];
      end
   end

   lock_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      locked |=> locked && (idle_cfg_reg[15:0] == $past(idle_cfg_reg[15:0])))
      else $error("locked configuration bits changed");
   resv_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      (idle_cfg_reg & ~ilmc_pkg::IDLE_CFG_WMASK) == 64'h0)
      else $error("reserved configuration bits nonzero");
   cfg_write_a: assert property (@(posedge sys_clk) disable iff (srst)
      msr_wr && hit_idle && !locked |=> idle_cfg_reg[2:0] == $past(msr_wdata[2:0]))
      else $error("limit field write lost");
   sequence cap_read_s;
      msr_rd && hit_cap;
   endsequence
   cap_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      cap_read_s |=> msr_rdata == cap_value)
      else $error("capability read wrong");
   err_resv_a: assert property (@(posedge sys_clk) disable iff (srst)
      err_cfg_reg[0] == 1'b0 && err_cfg_reg[63:2] == 62'h0)
      else $error("error config reserved bits set");
   no_limit_a: assert property (@(posedge sys_clk) disable iff (srst)
      idle_cfg_reg[2:0] == 3'h7 |=> idle_depth_limit == 7'h40)
      else $error("unlimited code not decoded");
   no_third_a: assert property (@(posedge sys_clk) disable iff (srst)
      !code_valid |=> idle_depth_limit == 7'h01)
      else $error("undefined code not held shallow");
   redirect_a: assert property (@(posedge sys_clk) disable iff (srst)
      monitor_wait_instruction |-> $past(io_rd) && $past(idle_cfg_reg[10]))
      else $error("redirect without enable");
   limit_none_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_NONE |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_NONE)
      else $error("code 000b not decoded");
   limit_s2_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_S2 |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_S2)
      else $error("code 001b not decoded");
   limit_s6_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_S6 |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_S6)
      else $error("code 010b not decoded");
   limit_s6r_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_S6R |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_S6R)
      else $error("code 011b not decoded");
   limit_s7_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_S7 |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_S7)
      else $error("code 100b not decoded");
   limit_s7s_a: assert property (@(posedge sys_clk) disable iff (srst)
      limit_field == ilmc_pkg::LIM_S7S |=> idle_depth_limit == ilmc_pkg::ILMC_DEPTH_S7S)
      else $error("code 101b not decoded");
   sequence io_match_s;
      io_rd && idle_cfg_reg[ilmc_pkg::IO_REDIR_BIT] && (io_rd_port == io_capture_base_register);
   endsequence
   redirect_on_a: assert property (@(posedge sys_clk) disable iff (srst)
      io_match_s |=> monitor_wait_instruction)
      else $error("matching read not redirected");
   redirect_port_a: assert property (@(posedge sys_clk) disable iff (srst)
      monitor_wait_instruction |-> $past(io_rd_port) == $past(io_capture_base_register))
      else $error("redirect on wrong port");
   sequence lock_set_s;
      msr_wr && hit_idle && !locked && msr_wdata[ilmc_pkg::LOCK_BIT];
   endsequence
   sequence locked_wr_s;
      msr_wr && hit_idle && locked;
   endsequence
   lock_set_a: assert property (@(posedge sys_clk) disable iff (srst)
      lock_set_s |=> locked)
      else $error("lock bit not taken");
   lock_write_a: assert property (@(posedge sys_clk) disable iff (srst)
      locked_wr_s |=> $stable(idle_cfg_reg))
      else $error("write passed the lock");
   cfg_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(msr_wr && hit_idle) |=> $stable(idle_cfg_reg))
      else $error("configuration changed without write");
   sequence err_write_s;
      msr_wr && hit_err;
   endsequence
   err_write_a: assert property (@(posedge sys_clk) disable iff (srst)
      err_write_s |=> err_cfg_reg[ilmc_pkg::MEMLOG_BIT] == $past(msr_wdata[ilmc_pkg::MEMLOG_BIT]))
      else $error("log enable write lost");
   err_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(msr_wr && hit_err) |=> $stable(err_cfg_reg))
      else $error("error config changed without write");
   cap_resv_a: assert property (@(posedge sys_clk) disable iff (srst)
      cap_read_s |=> msr_rdata[15:12] == 4'h0 && msr_rdata[25] == 1'b0 && msr_rdata[63:27] == 37'h0)
      else $error("capability reserved bits set");
   sequence stray_access_s;
      (msr_rd || msr_wr) && !(hit_idle || hit_cap || hit_err);
   endsequence
   stray_fault_a: assert property (@(posedge sys_clk) disable iff (srst)
      stray_access_s |=> msr_fault)
      else $error("unmapped access not flagged");
   stray_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      msr_rd && !(hit_idle || hit_cap || hit_err) |=> msr_rdata == 64'h0)
      else $error("unmapped read not zero");
   fault_cause_a: assert property (@(posedge sys_clk) disable iff (srst)
      msr_fault |-> $past(msr_rd || msr_wr))
      else $error("fault without access");
   read_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      msr_rd && hit_idle |=> msr_rdata == $past(idle_cfg_reg))
      else $error("configuration read wrong");
   read_err_a: assert property (@(posedge sys_clk) disable iff (srst)
      msr_rd && hit_err |=> msr_rdata == $past(err_cfg_reg))
      else $error("error config read wrong");
   read_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      !msr_rd |=> $stable(msr_rdata))
      else $error("read data moved without read");
   reset_clears_a: assert property (@(posedge sys_clk)
      srst |=> !locked && idle_cfg_reg[15:0] == {13'h0, FACTORY_LIMIT} && msr_rdata == 64'h0
               && !msr_fault && !monitor_wait_instruction && !memory_controller_bank_log_en
               && idle_depth_limit == ilmc_pkg::ILMC_DEPTH_NONE)
      else $error("reset did not clear the block");
   memlog_a: assert property (@(posedge sys_clk) disable iff (srst)
      err_write_s ##1 1'b1 |=> memory_controller_bank_log_en == $past(msr_wdata[1], 2))
      else $error("log enable not following bit 1");
endmodule : ilmc_regs
`default_nettype wire

// ### test/ilmc_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ilmc_regs_tb;
   logic        sys_clk                  = 1'b0;
   logic        srst                     = 1'b1;
   logic        msr_wr                   = 1'b0;
   logic        msr_rd                   = 1'b0;
   logic [31:0] msr_addr                 = 32'h0;
   logic [63:0] msr_wdata                = 64'h0;
   logic        io_rd                    = 1'b0;
   logic [15:0] io_rd_port               = 16'h0;
   logic [15:0] io_capture_base_register = 16'h0CA8;
   logic [63:0] msr_rdata;
   logic        msr_fault;
   logic [6:0]  idle_depth_limit;
   logic        monitor_wait_instruction;
   logic        memory_controller_bank_log_en;
   int          errors                   = 0;
   int          num_checks               = 0;
   int          cycles                   = 0;
   // expected one-hot depth per code; 110b has no meaning and decodes to none
   logic [6:0]  depth_tab [8]            = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h01, 7'h40};

   always #2.5 sys_clk = ~sys_clk;

   // all-ones capability value shows that only defined fields pass
   ilmc_regs #(.FACTORY_LIMIT(3'h7), .MC_CAP_VALUE(64'hFFFF_FFFF_FFFF_FFFF)) i_ilmc_regs (
      .sys_clk(sys_clk), .srst(srst), .msr_wr(msr_wr), .msr_rd(msr_rd), .msr_addr(msr_addr),
      .msr_wdata(msr_wdata), .io_rd(io_rd), .io_rd_port(io_rd_port),
      .io_capture_base_register(io_capture_base_register), .msr_rdata(msr_rdata), .msr_fault(msr_fault),
      .idle_depth_limit(idle_depth_limit), .monitor_wait_instruction(monitor_wait_instruction),
      .memory_controller_bank_log_en(memory_controller_bank_log_en));

   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // called at a falling edge; the idle cycle keeps strobes from being reassigned in one step
   task wr(input logic [31:0] a, input logic [63:0] d);
      msr_addr = a; msr_wdata = d; msr_wr = 1'b1;
      @(negedge sys_clk) msr_wr = 1'b0;
      @(negedge sys_clk);
   endtask : wr

   task rd(input logic [31:0] a, input logic [63:0] exp, input logic expf);
      msr_addr = a; msr_rd = 1'b1;
      @(negedge sys_clk) msr_rd = 1'b0;
      chk(msr_rdata, exp);
      chk({63'h0, msr_fault}, {63'h0, expf});
      @(negedge sys_clk);
   endtask : rd

   task io(input logic [15:0] p, input logic exp);
      io_rd_port = p; io_rd = 1'b1;
      @(negedge sys_clk) io_rd = 1'b0;
      chk({63'h0, monitor_wait_instruction}, {63'h0, exp});
      @(negedge sys_clk);
   endtask : io

   task tally_and_finish;
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // the whole sequence needs well under 400 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         $display("[FAIL] %0t run did not complete", $time);
         tally_and_finish();
      end
   end

   initial begin
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      @(negedge sys_clk);
      chk({57'h0, idle_depth_limit}, 64'h40);
      rd(ilmc_pkg::ADDR_IDLE_CFG, 64'h7, 1'b0);
      rd(ilmc_pkg::ADDR_MC_CAP, 64'h0000_0000_05FF_0FFF, 1'b0);
      wr(ilmc_pkg::ADDR_MC_CAP, 64'h0);
      rd(ilmc_pkg::ADDR_MC_CAP, 64'h0000_0000_05FF_0FFF, 1'b0);
      rd(ilmc_pkg::ADDR_ERR_CFG, 64'h0, 1'b0);
      rd(32'h0000_0180, 64'h0, 1'b1);
      for (int c = 0; c < 8; c++) begin
         wr(ilmc_pkg::ADDR_IDLE_CFG, 64'hFFFF_FFFF_FFFF_7BF8 | 64'(c));
         chk({57'h0, idle_depth_limit}, {57'h0, depth_tab[c]});
         rd(ilmc_pkg::ADDR_IDLE_CFG, 64'(c), 1'b0);
      end
      io(16'h0CA8, 1'b0);
      wr(ilmc_pkg::ADDR_IDLE_CFG, 64'h0000_0000_0000_0407);
      io(16'h0CA8, 1'b1);
      io(16'h0CA9, 1'b0);
      wr(ilmc_pkg::ADDR_ERR_CFG, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(ilmc_pkg::ADDR_ERR_CFG, 64'h2, 1'b0);
      chk({63'h0, memory_controller_bank_log_en}, 64'h1);
      wr(ilmc_pkg::ADDR_ERR_CFG, 64'h0);
      chk({63'h0, memory_controller_bank_log_en}, 64'h0);
      wr(ilmc_pkg::ADDR_IDLE_CFG, 64'h0000_0000_0000_8401);
      rd(ilmc_pkg::ADDR_IDLE_CFG, 64'h8401, 1'b0);
      wr(ilmc_pkg::ADDR_IDLE_CFG, 64'h0000_0000_0000_0002);
      rd(ilmc_pkg::ADDR_IDLE_CFG, 64'h8401, 1'b0);
      chk({57'h0, idle_depth_limit}, 64'h02);
      srst = 1'b1;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd(ilmc_pkg::ADDR_IDLE_CFG, 64'h7, 1'b0);
      wr(ilmc_pkg::ADDR_IDLE_CFG, 64'h1);
      rd(ilmc_pkg::ADDR_IDLE_CFG, 64'h1, 1'b0);
      tally_and_finish();
   end
endmodule : ilmc_regs_tb
`default_nettype wire
